/* File: shared/scm_params.svh */
`ifndef SCM_PARAMS_SVH
`define SCM_PARAMS_SVH
// ********
// Register byte offsets
// ********
`define SCM_A_CTRL 8'h00
`define SCM_A_FBINT 8'h04
`define SCM_A_FBFRAC 8'h08
`define SCM_A_OFSLO 8'h0C
`define SCM_A_OFSHI 8'h10
`define SCM_A_DIV0 8'h14
`define SCM_A_LOSNOM 8'h24
`define SCM_A_LOSMRG 8'h28
`define SCM_A_ACTNOM 8'h2C
`define SCM_A_ACTMRG 8'h30
`define SCM_A_ACTWIN 8'h34
`define SCM_A_STATUS 8'h38
`define SCM_A_EVENT 8'h3C
`define SCM_A_MASK 8'h40
// ********
// Control field positions
// ********
`define SCM_C_DBL 0
`define SCM_C_RSEL 1
`define SCM_C_BYP 2
`define SCM_C_SYN 3
`define SCM_C_OESEL 4
`define SCM_C_WLOCK 5
`define SCM_C_DSYNC 6
`define SCM_C_LRNG 7
`define SCM_C_DIS 8
`define SCM_C_PD 12
`define SCM_C_DST 16
// ********
// Event and status field positions
// ********
`define SCM_E_LOL 0
`define SCM_E_LOS 1
`define SCM_E_ACT 4
`define SCM_S_LOCK 0
`define SCM_S_RUN 1
`define SCM_S_SYNC 2
`define SCM_S_LOS 3
`define SCM_S_ACT 6
`define SCM_S_QUAL 8
// ********
// Reset values and timing
// ********
`define SCM_CTRL_RST 32'h0000_0000
`define SCM_PD_RST 4'h0
`define SCM_DIV_RST 12'h004
`define SCM_THR_RST 8'h01
`define SCM_SYNC_NS 50000
`define SCM_CLK_NS 100
`endif

/* File: shared/scm_pkg.sv */
package scm_pkg;
  typedef enum logic [2:0] {
    SCM_ST_PWRDN = 3'b000,
    SCM_ST_CFG = 3'b001,
    SCM_ST_SYNC = 3'b010,
    SCM_ST_LOCK = 3'b011,
    SCM_ST_RUN = 3'b100
  } scm_state_t;
  typedef enum logic [1:0] {
    SCM_DIS_LOW = 2'b00,
    SCM_DIS_HIGH = 2'b01,
    SCM_DIS_HIZ = 2'b10
  } scm_dis_t;
  typedef struct packed {
    logic [23:0] nom;
    logic [15:0] acc;
    logic [15:0] rej;
    logic [7:0] good;
    logic [7:0] fail;
    logic [23:0] edges;
  } scm_mon_cfg_t;
  typedef struct packed {
    logic p;
    logic n;
    logic oe_n;
  } scm_pin_t;
  // True when count lies within nominal plus or minus margin
  function automatic logic scm_within(input logic [23:0] cnt, input logic [23:0] nom,
                                      input logic [15:0] m);
    logic [24:0] d;
    d = (cnt >= nom) ? {1'b0, cnt - nom} : {1'b0, nom - cnt};
    return d <= {9'h000, m};
  endfunction
endpackage

/* File: core/scm_ref_mon.sv */
`include "scm_params.svh"
module scm_ref_mon (
  input wire logic clk,
  input wire logic resetn,
  input wire logic edge_tick,
  input wire scm_pkg::scm_mon_cfg_t cfg,
  output logic sts
);
  logic [23:0] cnt;
  logic [23:0] seen;
  logic [7:0] good_cnt;
  logic [7:0] fail_cnt;
  logic timeout;
  logic win_end;
  logic done;
  logic rej;
  logic acc;
  // A missing edge ends the window as soon as the reject bound is passed
  assign timeout = {1'b0, cnt} > ({1'b0, cfg.nom} + {9'h000, cfg.rej});
  assign win_end = edge_tick && ((seen + 24'h000001) >= cfg.edges);
  assign done = win_end || timeout;
  assign rej = timeout || !scm_pkg::scm_within(cnt, cfg.nom, cfg.rej);
  assign acc = !timeout && scm_pkg::scm_within(cnt, cfg.nom, cfg.acc);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 24'h000000; // RULE_25
      seen <= 24'h000000;
    end else if (done) begin
      cnt <= 24'h000000;
      seen <= 24'h000000;
    end else begin
      cnt <= cnt + 24'h000001; // RULE_18
      if (edge_tick) begin
        seen <= seen + 24'h000001;
      end
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      good_cnt <= 8'h00;
      fail_cnt <= 8'h00;
      sts <= 1'b1; // RULE_25
    end else if (done && rej) begin
      good_cnt <= 8'h00; // RULE_20
      if (fail_cnt != 8'hFF) begin
        fail_cnt <= fail_cnt + 8'h01;
      end
      if ((fail_cnt + 8'h01) >= cfg.fail) begin
        sts <= 1'b1; // RULE_22
      end
    end else if (done && acc) begin
      fail_cnt <= 8'h00; // RULE_20
      if (good_cnt != 8'hFF) begin
        good_cnt <= good_cnt + 8'h01;
      end
      if ((good_cnt + 8'h01) >= cfg.good) begin
        sts <= 1'b0; // RULE_21
      end
    end
  end
endmodule // scm_ref_mon

/* File: core/scm_out_div.sv */
module scm_out_div #(
  parameter int RW = 12
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sync,
  input wire logic [RW-1:0] ratio,
  input wire logic en_req,
  input wire logic pd,
  input wire logic [1:0] dis_state,
  output scm_pkg::scm_pin_t pin
);
  logic [RW-1:0] cnt;
  logic [RW-1:0] top;
  logic q;
  logic en;
  assign top = (ratio < RW'(2)) ? RW'(1) : ratio - RW'(1);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
      q <= 1'b0;
    end else if (sync) begin
      cnt <= '0; // RULE_10
      q <= 1'b0;
    end else begin
      cnt <= (cnt >= top) ? '0 : cnt + RW'(1); // RULE_08
      q <= (cnt >= top) ? 1'b1 : ((cnt + RW'(1)) < ((top + RW'(1)) >> 1));
    end
  end
  // Enable follows the request only while the divided clock is low or during sync; power-down clears it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en <= 1'b0;
    end else if (pd) begin
      en <= 1'b0; // RULE_12
    end else if (!q || sync) begin
      en <= en_req; // RULE_09
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin <= '{p: 1'b0, n: 1'b0, oe_n: 1'b1};
    end else if (pd) begin
      pin <= '{p: 1'b0, n: 1'b0, oe_n: 1'b1}; // RULE_12
    end else if (en) begin
      pin <= '{p: q, n: !q, oe_n: 1'b0};
    end else begin
      case (dis_state) // RULE_11
        scm_pkg::SCM_DIS_HIGH: pin <= '{p: 1'b1, n: 1'b1, oe_n: 1'b0};
        scm_pkg::SCM_DIS_HIZ: pin <= '{p: 1'b0, n: 1'b0, oe_n: 1'b1};
        default: pin <= '{p: 1'b0, n: 1'b0, oe_n: 1'b0};
      endcase
    end
  end
endmodule // scm_out_div

/* File: core/scm_top.sv */
`include "scm_params.svh"
// Summary of operation
// RULE_01: Doubler enable bit doubles the chosen reference before the phase detector.
// RULE_02: Reference-select bit picks crystal or external input for the doubler.
// RULE_03: Software bypasses the third pole only with a zero fraction.
// RULE_04: Feedback ratio is integer plus 27-bit numerator over two to 27.
// RULE_05: Lock is readable; a lock falling edge sets a sticky loss event.
// RULE_06: Software sets lock-detector range to the applied reference range.
// RULE_07: In synthesizer mode the offset word trims frequency, LSB two to minus 40.
// RULE_08: Four integer dividers each divide the VCO clock by their ratio.
// RULE_09: Output enable and disable act only while the output clock is low.
// RULE_10: Dividers resync after start-up and on sync write, pausing outputs 50us.
// RULE_11: Disabled outputs hold low by default, or high or tristate by field.
// RULE_12: Power-down tristates the output and the enable is then ignored.
// RULE_13: Outputs stay tristated until supplies settle, then come up disabled low.
// RULE_14: Start-up may wait for first lock; afterwards lock no longer gates outputs.
// RULE_15: With enable-source 1, each disable bit alone controls its output.
// RULE_16: With enable-source 0, the pin gates all outputs, disable bits still apply.
// RULE_17: Signal monitors on both references and crystal; activity on both references.
// RULE_18: Activity monitor counts system clocks over a whole number of reference edges.
// RULE_19: Counts are compared against nominal plus or minus accept and reject margins.
// RULE_20: Reject increments fail and zeroes good; accept zeroes fail, increments good.
// RULE_21: Failure clears at programmed good count, or at one for activity.
// RULE_22: Failure sets at programmed fail count, or at one for activity.
// RULE_23: Reference disqualified by OR of unmasked signal and activity failures.
// RULE_24: Valid-to-invalid sets a sticky event; clear write ignored while failing.
// RULE_25: Counters start at zero and status reads invalid until first qualified.
module scm_top #(
  parameter int IW = 9,
  parameter int DW = 12
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic ref0_clk,
  input wire logic ref1_clk,
  input wire logic xtal_clk,
  input wire logic pll_lock,
  input wire logic output_enable_pin,
  input wire logic supplies_stable,
  input wire logic config_done,
  output logic doubler_en,
  output logic ref_sel_ext,
  output logic third_pole_bypass,
  output logic lock_range,
  output logic [IW-1:0] feedback_integer_word,
  output logic [26:0] feedback_fraction_word,
  output logic [39:0] freq_offset,
  output logic [1:0] ref_qualified,
  output logic xtal_qualified,
  output logic [3:0] out_p,
  output logic [3:0] out_n,
  output logic [3:0] out_oe_n
);
  localparam int SYNC_CYC = (`SCM_SYNC_NS + `SCM_CLK_NS - 1) / `SCM_CLK_NS;
  localparam logic [15:0] SYNC_LEN = 16'(SYNC_CYC);
  // ********
  // Input synchronisers
  // ********
  logic [6:0] sync1;
  logic [6:0] sync2;
  logic [2:0] ref_prev;
  logic [2:0] ref_tick;
  logic lock_s;
  logic lock_prev;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= 7'h00;
      sync2 <= 7'h00;
      ref_prev <= 3'h0;
      lock_prev <= 1'b0;
    end else begin
      sync1 <= {config_done, supplies_stable, output_enable_pin, pll_lock,
                xtal_clk, ref1_clk, ref0_clk};
      sync2 <= sync1;
      ref_prev <= sync2[2:0];
      lock_prev <= lock_s;
    end
  end
  assign ref_tick = sync2[2:0] & ~ref_prev;
  assign lock_s = sync2[3];
  // ********
  // Configuration registers
  // ********
  logic [31:0] ctrl;
  logic [31:0] ofs_lo;
  logic [7:0] ofs_hi;
  logic [DW-1:0] ratio [4];
  logic [23:0] los_nom;
  logic [31:0] los_mrg;
  logic [23:0] act_nom;
  logic [31:0] act_mrg;
  logic [23:0] act_win;
  logic [4:0] mask;
  logic [5:0] evt;
  logic acc_wr;
  logic acc_rd;
  logic sync_req;
  assign acc_wr = write && !waitrequest;
  assign acc_rd = read && !waitrequest;
  assign sync_req = acc_wr && (address == `SCM_A_CTRL) && writedata[`SCM_C_DSYNC];
  // Request is held one cycle, then answered with waitrequest low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= `SCM_CTRL_RST;
      ctrl[`SCM_C_PD +: 4] <= `SCM_PD_RST;
      feedback_integer_word <= '0;
      feedback_fraction_word <= 27'h0000000;
      ofs_lo <= 32'h0000_0000;
      ofs_hi <= 8'h00;
      los_nom <= 24'h000000;
      los_mrg <= {`SCM_THR_RST, `SCM_THR_RST, 16'h0000};
      act_nom <= 24'h000000;
      act_mrg <= 32'h0000_0000;
      act_win <= 24'h000001;
      mask <= 5'h00;
    end else if (acc_wr) begin
      case (address)
        `SCM_A_CTRL: ctrl <= writedata & ~(32'h1 << `SCM_C_DSYNC);
        `SCM_A_FBINT: feedback_integer_word <= writedata[IW-1:0]; // RULE_04
        `SCM_A_FBFRAC: feedback_fraction_word <= writedata[26:0]; // RULE_04
        `SCM_A_OFSLO: ofs_lo <= writedata;
        `SCM_A_OFSHI: ofs_hi <= writedata[7:0];
        `SCM_A_LOSNOM: los_nom <= writedata[23:0];
        `SCM_A_LOSMRG: los_mrg <= writedata;
        `SCM_A_ACTNOM: act_nom <= writedata[23:0];
        `SCM_A_ACTMRG: act_mrg <= writedata;
        `SCM_A_ACTWIN: act_win <= writedata[23:0];
        `SCM_A_MASK: mask <= writedata[4:0];
        default: ;
      endcase
    end
  end
  for (genvar i = 0; i < 4; i++) begin : g_ratio
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        ratio[i] <= DW'(`SCM_DIV_RST);
      end else if (acc_wr && (address == (`SCM_A_DIV0 + 8'(4 * i)))) begin
        ratio[i] <= writedata[DW-1:0]; // RULE_08
      end
    end
  end
  // ********
  // Analog control outputs
  // ********
  assign doubler_en = ctrl[`SCM_C_DBL]; // RULE_01
  assign ref_sel_ext = ctrl[`SCM_C_RSEL]; // RULE_02
  assign third_pole_bypass = ctrl[`SCM_C_BYP]; // RULE_03
  assign lock_range = ctrl[`SCM_C_LRNG]; // RULE_06
  // Offset reaches the feedback path only in synthesizer mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      freq_offset <= 40'h00_0000_0000;
    end else begin
      freq_offset <= ctrl[`SCM_C_SYN] ? {ofs_hi, ofs_lo} : 40'h00_0000_0000; // RULE_07
    end
  end
  // ********
  // Reference monitors
  // ********
  scm_pkg::scm_mon_cfg_t los_cfg;
  scm_pkg::scm_mon_cfg_t act_cfg;
  logic [2:0] los_sts;
  logic [1:0] act_sts;
  logic [2:0] los_prev;
  logic [1:0] act_prev;
  logic [2:0] ref_bad;
  always_comb begin
    los_cfg = '{nom: los_nom, acc: {8'h00, los_mrg[7:0]}, rej: {8'h00, los_mrg[15:8]},
                good: los_mrg[23:16], fail: los_mrg[31:24], edges: 24'h000001};
    act_cfg = '{nom: act_nom, acc: act_mrg[15:0], rej: act_mrg[31:16],
                good: 8'h01, fail: 8'h01, edges: act_win}; // RULE_21 RULE_22
  end
  for (genvar i = 0; i < 3; i++) begin : g_los
    scm_ref_mon u_mon (
      .clk(clk),
      .resetn(resetn),
      .edge_tick(ref_tick[i]),
      .cfg(los_cfg),
      .sts(los_sts[i])
    ); // RULE_17 RULE_19
  end
  for (genvar i = 0; i < 2; i++) begin : g_act
    scm_ref_mon u_mon (
      .clk(clk),
      .resetn(resetn),
      .edge_tick(ref_tick[i]),
      .cfg(act_cfg),
      .sts(act_sts[i])
    ); // RULE_17 RULE_18
  end
  assign ref_bad = (los_sts & ~mask[2:0]) | {1'b0, act_sts & ~mask[4:3]};
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_qualified <= 2'b00;
      xtal_qualified <= 1'b0;
      los_prev <= 3'h7;
      act_prev <= 2'h3;
    end else begin
      ref_qualified <= ~ref_bad[1:0]; // RULE_23
      xtal_qualified <= !ref_bad[2];
      los_prev <= los_sts;
      act_prev <= act_sts;
    end
  end
  // ********
  // Sticky events
  // ********
  logic [5:0] evt_set;
  logic [5:0] evt_hold;
  logic [5:0] evt_clr;
  assign evt_set = {act_sts & ~act_prev, los_sts & ~los_prev, lock_prev & !lock_s};
  assign evt_hold = {act_sts, los_sts, !lock_s};
  assign evt_clr = (acc_wr && (address == `SCM_A_EVENT)) ? writedata[5:0] : 6'h00;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      evt <= 6'h00;
    end else begin
      evt[`SCM_E_LOL] <= evt_set[`SCM_E_LOL] | (evt[`SCM_E_LOL] & !evt_clr[`SCM_E_LOL]); // RULE_05
      evt[5:1] <= evt_set[5:1] | (evt[5:1] & ~(evt_clr[5:1] & ~evt_hold[5:1])); // RULE_24
    end
  end
  // ********
  // Start-up sequence and divider sync
  // ********
  scm_pkg::scm_state_t state;
  logic [15:0] sync_cnt;
  logic syncing;
  assign syncing = sync_cnt != 16'h0000;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= scm_pkg::SCM_ST_PWRDN;
      sync_cnt <= 16'h0000;
    end else begin
      if (syncing) begin
        sync_cnt <= sync_cnt - 16'h0001;
      end
      case (state)
        scm_pkg::SCM_ST_PWRDN: begin
          if (sync2[5]) begin
            state <= scm_pkg::SCM_ST_CFG; // RULE_13
          end
        end
        scm_pkg::SCM_ST_CFG: begin
          if (sync2[6]) begin
            state <= scm_pkg::SCM_ST_SYNC;
            sync_cnt <= SYNC_LEN; // RULE_10
          end
        end
        scm_pkg::SCM_ST_SYNC: begin
          if (!syncing) begin
            state <= scm_pkg::SCM_ST_LOCK;
          end
        end
        scm_pkg::SCM_ST_LOCK: begin
          if (lock_s || !ctrl[`SCM_C_WLOCK]) begin
            state <= scm_pkg::SCM_ST_RUN; // RULE_14
          end
        end
        scm_pkg::SCM_ST_RUN: begin
          if (sync_req) begin
            sync_cnt <= SYNC_LEN; // RULE_10
          end
        end
        default: state <= scm_pkg::SCM_ST_PWRDN;
      endcase
    end
  end
  // ********
  // Output dividers and drivers
  // ********
  logic run;
  logic startup_pd;
  assign run = state == scm_pkg::SCM_ST_RUN;
  assign startup_pd = state == scm_pkg::SCM_ST_PWRDN;
  for (genvar i = 0; i < 4; i++) begin : g_out
    logic en_req;
    logic pd;
    scm_pkg::scm_pin_t pin;
    assign pd = startup_pd || ctrl[`SCM_C_PD + i]; // RULE_12 RULE_13
    // Pin gating applies only when the enable source is the pin
    assign en_req = run && !ctrl[`SCM_C_DIS + i] &&
                    (ctrl[`SCM_C_OESEL] || sync2[4]); // RULE_15 RULE_16
    scm_out_div #(.RW(DW)) u_div (
      .clk(clk),
      .resetn(resetn),
      .sync(syncing || !run && state != scm_pkg::SCM_ST_LOCK),
      .ratio(ratio[i]),
      .en_req(en_req),
      .pd(pd),
      .dis_state(ctrl[`SCM_C_DST + 2 * i +: 2]),
      .pin(pin)
    );
    assign out_p[i] = pin.p;
    assign out_n[i] = pin.n;
    assign out_oe_n[i] = pin.oe_n;
  end
  // ********
  // Read path
  // ********
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      readdata <= 32'h0000_0000;
    end else if ((read || write) && waitrequest) begin
      readdata <= 32'h0000_0000;
      case (address)
        `SCM_A_CTRL: readdata <= ctrl;
        `SCM_A_FBINT: readdata[IW-1:0] <= feedback_integer_word;
        `SCM_A_FBFRAC: readdata[26:0] <= feedback_fraction_word;
        `SCM_A_OFSLO: readdata <= ofs_lo;
        `SCM_A_OFSHI: readdata[7:0] <= ofs_hi;
        `SCM_A_DIV0: readdata[DW-1:0] <= ratio[0];
        `SCM_A_DIV0 + 8'h04: readdata[DW-1:0] <= ratio[1];
        `SCM_A_DIV0 + 8'h08: readdata[DW-1:0] <= ratio[2];
        `SCM_A_DIV0 + 8'h0C: readdata[DW-1:0] <= ratio[3];
        `SCM_A_LOSNOM: readdata[23:0] <= los_nom;
        `SCM_A_LOSMRG: readdata <= los_mrg;
        `SCM_A_ACTNOM: readdata[23:0] <= act_nom;
        `SCM_A_ACTMRG: readdata <= act_mrg;
        `SCM_A_ACTWIN: readdata[23:0] <= act_win;
        `SCM_A_STATUS: begin
          readdata[`SCM_S_LOCK] <= lock_s; // RULE_05
          readdata[`SCM_S_RUN] <= run;
          readdata[`SCM_S_SYNC] <= syncing;
          readdata[`SCM_S_LOS +: 3] <= los_sts;
          readdata[`SCM_S_ACT +: 2] <= act_sts;
          readdata[`SCM_S_QUAL +: 2] <= ~ref_bad[1:0];
        end
        `SCM_A_EVENT: readdata[5:0] <= evt;
        `SCM_A_MASK: readdata[4:0] <= mask;
        default: ;
      endcase
    end
  end
endmodule // scm_top

/* File: bench/scm_props.sv */
// ********
// Bus handshake and output pin checks
// ********
module scm_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic waitrequest,
  input wire logic output_enable_pin,
  input wire logic doubler_en,
  input wire logic ref_sel_ext,
  input wire logic [26:0] feedback_fraction_word,
  input wire logic [39:0] freq_offset,
  input wire logic [3:0] out_p,
  input wire logic [3:0] out_n,
  input wire logic [3:0] out_oe_n
);
  logic [31:0] ctrl;
  logic [7:0] quiet;
  logic done;
  logic [3:0] off;
  assign done = write && !waitrequest;
  // Outputs meant to be disabled and not powered down
  assign off = ((ctrl[4] || output_enable_pin) ? ctrl[11:8] : 4'hF) & ~ctrl[15:12];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= '0;
    end else if (done && address == 8'h00) begin
      ctrl <= writedata;
    end
  end
  // Cycles since the last change that moves the outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      quiet <= 8'h00;
    end else if ((done && address < 8'h24) || $changed(output_enable_pin)) begin
      quiet <= 8'h00;
    end else if (quiet != 8'hFF) begin
      quiet <= quiet + 8'h01;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wait_single_a: assert property ($fell(waitrequest) |=> waitrequest)
    else $error("answer lasted more than one cycle");
  wait_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered next cycle");
  wait_cause_a: assert property (!waitrequest |-> $past(read || write))
    else $error("answer without request");
  frac_store_a: assert property (done && address == 8'h08 |=>
    feedback_fraction_word == $past(writedata[26:0])) else $error("fraction not stored");
  ref_pick_a: assert property (done && address == 8'h00 |=>
    doubler_en == $past(writedata[0]) && ref_sel_ext == $past(writedata[1]))
    else $error("reference controls not stored");
  offset_off_a: assert property (!ctrl[3] && quiet > 8'h02 |->
    freq_offset == 40'h0) else $error("offset applied outside synth mode");
  pd_tristate_a: assert property (quiet > 8'h18 |->
    (ctrl[15:12] & ~out_oe_n) == 4'h0) else $error("powered-down output driven");
  off_low_a: assert property (quiet > 8'h18 && ctrl[23:16] == 8'h00 |->
    (off & (out_p | out_n | out_oe_n)) == 4'h0) else $error("disabled output not low");
endmodule // scm_props

bind scm_top scm_props chk (.clk, .resetn, .address, .read, .write, .writedata, .waitrequest,
  .output_enable_pin, .doubler_en, .ref_sel_ext, .feedback_fraction_word, .freq_offset,
  .out_p, .out_n, .out_oe_n);

/* File: bench/scm_recv.sv */
// ********
// Clock receivers: count edges and measure periods
// ********
module scm_recv (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] out_p,
  input wire logic [3:0] out_oe_n,
  output logic [3:0][15:0] rises,
  output logic [3:0][7:0] per
);
  logic [3:0] last;
  logic [3:0][7:0] run;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last <= 4'h0;
      rises <= '0;
      per <= '0;
      run <= '0;
    end else begin
      last <= out_p & ~out_oe_n;
      for (int i = 0; i < 4; i++) begin
        if (!out_oe_n[i] && out_p[i] && !last[i]) begin
          rises[i] <= rises[i] + 16'h0001;
          per[i] <= run[i];
          run[i] <= 8'h01;
        end else begin
          run[i] <= run[i] + 8'h01;
        end
      end
    end
  end
endmodule // scm_recv

/* File: bench/scm_top_bench.sv */
module scm_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, resetn, read, write, waitrequest, pll_lock, output_enable_pin;
  logic supplies_stable, config_done, doubler_en, ref_sel_ext, xtal_qualified, tpb, lrng;
  logic [8:0] fbi;
  logic ref0_clk, ref1_clk, xtal_clk;
  logic [7:0] address, tick;
  logic [31:0] writedata, readdata;
  logic [26:0] feedback_fraction_word;
  logic [39:0] freq_offset;
  logic [1:0] ref_qualified;
  logic [2:0] run_ref;
  logic [3:0] out_p, out_n, out_oe_n;
  logic [3:0][15:0] rises, snap;
  logic [3:0][7:0] per, rat;
  logic [31:0] mdl [int];
  int err_total, comparisons, k;
  // ********
  // Design, receivers and stimulus clocks
  // ********
  scm_top dut (.clk, .resetn, .address, .read, .write, .writedata, .readdata, .waitrequest,
    .ref0_clk, .ref1_clk, .xtal_clk, .pll_lock, .output_enable_pin, .supplies_stable,
    .config_done, .doubler_en, .ref_sel_ext, .third_pole_bypass(tpb), .lock_range(lrng),
    .feedback_integer_word(fbi), .feedback_fraction_word, .freq_offset, .ref_qualified,
    .xtal_qualified, .out_p, .out_n, .out_oe_n);
  scm_recv rx (.clk, .resetn, .out_p, .out_oe_n, .rises, .per);
  assign ref0_clk = tick[3] & run_ref[0];
  assign ref1_clk = tick[3] & run_ref[1];
  assign xtal_clk = tick[3] & run_ref[2];
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    tick <= tick + 8'h01;
  end
  // ********
  // Checking and bus tasks
  // ********
  task automatic results();
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    address <= a;
    read <= rd;
    write <= !rd;
    writedata <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n == 20) begin
      err_total++;
      results();
    end
  endtask
  function automatic logic [31:0] msk(input logic [7:0] a);
    case (a)
      8'h00: return 32'h00FF_FFBF;
      8'h04: return 32'h0000_01FF;
      8'h08: return 32'h07FF_FFFF;
      8'h10: return 32'h0000_00FF;
      8'h14, 8'h18, 8'h1C, 8'h20: return 32'h0000_0FFF;
      8'h24, 8'h2C, 8'h34: return 32'h00FF_FFFF;
      8'h40: return 32'h0000_001F;
      default: return 32'hFFFF_FFFF;
    endcase
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
    if (a <= 8'h34 || a == 8'h40) mdl[a] = d & msk(a);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b1, a, 32'h0, q);
    chk(40'(q & m), 40'(e));
  endtask
  task automatic wait_q(input logic [2:0] e);
    int n;
    for (n = 0; n < 600; n++) begin
      @(posedge clk);
      if ({xtal_qualified, ref_qualified} === e) break;
    end
    chk(40'({xtal_qualified, ref_qualified}), 40'(e));
    if (n == 600) results();
  endtask
  function automatic logic [3:0] moved();
    for (int i = 0; i < 4; i++) begin
      moved[i] = rises[i] != snap[i];
    end
  endfunction
  // ********
  // Main sequence
  // ********
  initial begin
    {resetn, read, write, pll_lock, supplies_stable, config_done} = 6'h00;
    output_enable_pin = 1'b1;
    address = 8'h00;
    writedata = 32'h0;
    tick = 8'h00;
    run_ref = 3'b111;
    void'($urandom(32'h28b9));
    mdl[0] = 32'h0;
    mdl[40] = 32'h0101_0000;
    mdl[52] = 32'h0000_0001;
    for (k = 20; k < 36; k += 4) mdl[k] = 32'h0000_0004;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    chk(40'({xtal_qualified, ref_qualified}), 40'h0);
    for (k = 0; k < 14; k += 5) rd(8'(4 * k), '1, mdl[4 * k]);
    wr(8'h80, $urandom);
    rd(8'h80, '1, 32'h0);
    chk(40'(out_oe_n), 40'hF);
    for (k = 1; k < 5; k++) wr(8'(4 * k), $urandom);
    wr(8'h00, 32'h0000_F02B);
    for (k = 0; k < 5; k++) rd(8'(4 * k), '1, mdl[4 * k]);
    chk(40'({fbi, feedback_fraction_word}), 40'({mdl[4][8:0], mdl[8][26:0]}));
    chk(freq_offset, {mdl[16][7:0], mdl[12]});
    chk(40'({lrng, tpb, ref_sel_ext, doubler_en}), 40'h3);
    supplies_stable <= 1'b1;
    config_done <= 1'b1;
    repeat (900) @(posedge clk);
    rd(8'h38, 32'h2, 32'h0);
    pll_lock <= 1'b1;
    repeat (10) @(posedge clk);
    rd(8'h38, 32'h3, 32'h3);
    for (k = 0; k < 4; k++) begin
      rat[k] = 8'(2 + $urandom_range(7));
      wr(8'(8'h14 + 4 * k), 32'(rat[k]));
    end
    wr(8'h00, 32'h0000_023B);
    repeat (100) @(posedge clk);
    for (k = 0; k < 4; k += 2) chk(40'(per[k]), 40'(rat[k]));
    chk(40'({out_p[1], out_n[1], out_oe_n[1]}), 40'h0);
    wr(8'h00, 32'h0024_0F3B);
    repeat (40) @(posedge clk);
    chk(40'({out_oe_n, out_p & 4'hB, out_n & 4'hB}), 40'h422);
    wr(8'h00, 32'h0000_812B);
    output_enable_pin <= 1'b0;
    repeat (40) @(posedge clk);
    chk(40'({out_oe_n, (out_p | out_n) & 4'h7}), 40'h80);
    output_enable_pin <= 1'b1;
    repeat (40) @(posedge clk);
    snap = rises;
    repeat (40) @(posedge clk);
    chk(40'(moved()), 40'h6);
    wr(8'h00, 32'h0000_816B);
    repeat (5) @(posedge clk);
    snap = rises;
    repeat (300) @(posedge clk);
    chk(40'(moved()), 40'h0);
    pll_lock <= 1'b0;
    repeat (300) @(posedge clk);
    snap = rises;
    repeat (40) @(posedge clk);
    chk(40'(moved()), 40'h6);
    rd(8'h38, 32'h1, 32'h0);
    rd(8'h3C, 32'h1, 32'h1);
    pll_lock <= 1'b1;
    repeat (10) @(posedge clk);
    wr(8'h3C, 32'h1);
    rd(8'h3C, 32'h1, 32'h0);
    wr(8'h24, 32'h10);
    wr(8'h28, 32'h0202_0402);
    wr(8'h2C, 32'h40);
    wr(8'h30, 32'h0008_0004);
    wr(8'h34, 32'h4);
    for (k = 9; k < 14; k++) rd(8'(4 * k), '1, mdl[4 * k]);
    wait_q(3'h7);
    rd(8'h38, 32'h300, 32'h300);
    run_ref <= 3'b101;
    wait_q(3'h5);
    wr(8'h3C, 32'h4);
    rd(8'h3C, 32'h4, 32'h4);
    wr(8'h40, 32'h12);
    wait_q(3'h7);
    run_ref <= 3'b111;
    repeat (200) @(posedge clk);
    wr(8'h40, 32'h0);
    repeat (5) @(posedge clk);
    chk(40'({xtal_qualified, ref_qualified}), 40'h7);
    wr(8'h3C, 32'h24);
    rd(8'h3C, 32'h24, 32'h0);
    results();
  end
endmodule // scm_top_bench
